// ==== fco_consts.vh ====
// Register map, field positions, reset values and codes of the fault category block
`ifndef FCO_CONSTS_VH
`define FCO_CONSTS_VH

// Register byte addresses
`define FCO_ADDR_MASK1      8'h00
`define FCO_ADDR_MASK2      8'h04
`define FCO_ADDR_MASK3      8'h08
`define FCO_ADDR_MASK4      8'h0C
`define FCO_ADDR_FSEL0      8'h10
`define FCO_ADDR_FSEL1      8'h14
`define FCO_ADDR_FSEL2      8'h18
`define FCO_ADDR_FSEL3      8'h1C
`define FCO_ADDR_SNAP0      8'h20
`define FCO_ADDR_STATUS     8'h50

// Snapshot slot indices
`define FCO_SNAP_FCMD       4'd0
`define FCO_SNAP_OFREQ      4'd1
`define FCO_SNAP_OVOLT      4'd2
`define FCO_SNAP_BUSV       4'd3
`define FCO_SNAP_CURR       4'd4
`define FCO_SNAP_TEMP       4'd5
`define FCO_SNAP_SPEED      4'd6
`define FCO_SNAP_TORQ       4'd7
`define FCO_SNAP_INTERM     4'd8
`define FCO_SNAP_OUTTERM    4'd9
`define FCO_SNAP_DSTAT      4'd10
`define FCO_SNAP_NUM        11

// Category bit positions
`define FCO_CAT_CURRENT     0
`define FCO_CAT_VOLTAGE     1
`define FCO_CAT_OVERLOAD    2
`define FCO_CAT_SYSTEM      3
`define FCO_CAT_FEEDBACK    4
`define FCO_CAT_EXTERNAL    5
`define FCO_CAT_COMM        6
`define FCO_CAT_W           7

// Status register fields
`define FCO_STAT_CODE_LSB   0
`define FCO_STAT_CAT_LSB    8
`define FCO_STAT_CNT_LSB    16

// Terminal function codes that select fault mask one and fault mask four
`define FCO_FUNC_MASK1      8'h23
`define FCO_FUNC_MASK4      8'h26

// Reset values
`define FCO_RST_MASK        16'h0000
`define FCO_RST_FSEL        8'h00
`define FCO_RST_SNAP        16'h0000
`define FCO_NO_FAULT        8'h00

`endif

// ==== fco_monitor.sv ====
// Checker of APB answers and fault terminal timing
`timescale 1ns/1ps
`default_nettype none
module fco_monitor #(
    parameter NUM_TERM = 4,
    parameter CODE_W   = 8
) (
    input wire logic                clk_sys_i,    // Clock
    input wire logic                nrst_i,       // Reset, active low
    input wire logic                psel_i,       // Select
    input wire logic                penable_i,    // Access phase
    input wire logic                pwrite_i,     // Direction
    input wire logic [7:0]          paddr_i,      // Address
    input wire logic                pready_o,     // Ready
    input wire logic [31:0]         prdata_o,     // Read data
    input wire logic                pslverr_o,    // Error
    input wire logic [CODE_W-1:0]   fault_code_i, // Fault code
    input wire logic [NUM_TERM-1:0] fault_term_o  // Terminals
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    ////////////////////////////////////////////////////////////////
    // Bus phases
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_access;
        psel_i && penable_i;
    endsequence

    property p_ready_in_access;
        s_setup ##1 s_access |-> pready_o;
    endproperty
    property p_ready_qual;
        pready_o |-> s_access;
    endproperty
    property p_ready_pulse;
        pready_o |=> !pready_o;
    endproperty
    property p_err_with_ready;
        pslverr_o |-> pready_o;
    endproperty
    property p_ro_write_err;
        pready_o && pwrite_i && paddr_i >= 8'h20 |-> pslverr_o;
    endproperty
    property p_unaligned_err;
        pready_o && paddr_i[1:0] != 2'b00 |-> pslverr_o;
    endproperty
    property p_err_data_zero;
        pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0000_0000;
    endproperty
    // Terminal lags the code by two registers
    property p_no_fault_idle;
        fault_code_i == 8'h00 |-> ##2 fault_term_o == '0;
    endproperty
    property p_unlisted_idle;
        fault_code_i inside {8'h01, 8'h02, 8'h04} |-> ##2 fault_term_o == '0;
    endproperty

    a_ready_in_access: assert property (p_ready_in_access) else $error("no ready in access");
    a_ready_qual: assert property (p_ready_qual) else $error("ready outside access");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    a_ro_write_err: assert property (p_ro_write_err) else $error("read-only write accepted");
    a_unaligned_err: assert property (p_unaligned_err) else $error("unaligned access accepted");
    a_err_data_zero: assert property (p_err_data_zero) else $error("error read data not zero");
    a_no_fault_idle: assert property (p_no_fault_idle) else $error("terminal with no fault");
    a_unlisted_idle: assert property (p_unlisted_idle) else $error("unlisted code drives terminal");
endmodule
bind fco_top fco_monitor #(.NUM_TERM(NUM_TERM), .CODE_W(CODE_W)) u_mon (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .fault_code_i(fault_code_i),
    .fault_term_o(fault_term_o));
`default_nettype wire

// ==== fco_prot_model.sv ====
// Protection logic model: fault codes and live drive quantities
`timescale 1ns/1ps
`default_nettype none
module fco_prot_model (
    input  wire logic         clk_sys_i, // Clock
    output var  logic [7:0]   code_o,    // Fault code, 0 none
    output var  logic [175:0] live_o     // Eleven live quantities
);
    initial begin
        code_o = 8'h00;
        live_o = '0;
    end
    // Code is a level, held until the next fault replaces it
    task set_fault(input logic [7:0] c);
        @(posedge clk_sys_i);
        code_o <= c;
    endtask
    // Slot k carries base plus k, so a swapped slot shows
    task set_live(input logic [15:0] base);
        @(posedge clk_sys_i);
        for (int k = 0; k < 11; k++) live_o[16*k +: 16] <= base + 16'(k);
    endtask
endmodule
`default_nettype wire

// ==== fco_top.v ====
// Fault category classifier, fault output terminals and fault snapshot registers
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fco_consts.vh"

////////////////////////////////////////////////////////////////////////////
// Operating notes
// - Fault codes and live values come from logic on this clock, no sync
// - A fault event is a nonzero code that differs from the last cycle
// - A code held for many cycles is one event and one capture
// - Unlisted nonzero codes still capture, but set no category
// - Back-to-back different codes capture on every cycle
// - Snapshots keep the last event only; no history is held here
// - Snapshot words are kept raw; signed values keep their sign bit
// - Terminals are levels that follow the active code, not latched
// - Terminal function 35 to 38 picks mask one to four
// - Other function values leave the terminal low in this block
// - Mask bits 7 to 15 have no category, so they never match
// - Mask bit 4 never matches: no code maps to the feedback class
// - Category reaches the status word one cycle after the code
// - Terminals follow one cycle later again, two after the code
// - APB answers in the first access cycle, never with more waits
// - Writes to snapshot or status addresses are refused with an error
// - Unaligned or unmapped addresses read zero and raise an error
// - Error reads return zero so stale data never leaks
// - Read data holds after the answer until the next setup
// - Function selects are 8 bits; upper write data bits are dropped
// - Reset clears masks, selects, snapshots and status
// - Event counter wraps at 16 bits; software compares differences

module fco_top #(
    parameter NUM_TERM = 4,
    parameter CODE_W   = 8
) (
    input  wire                clk_sys_i,      // System clock, 125 MHz
    input  wire                nrst_i,         // Async reset, active low
    // APB slave
    input  wire                psel_i,         // Select
    input  wire                penable_i,      // Access phase
    input  wire                pwrite_i,       // Write direction
    input  wire [7:0]          paddr_i,        // Byte address
    input  wire [31:0]         pwdata_i,       // Write data
    output wire                pready_o,       // Ready, registered
    output wire [31:0]         prdata_o,       // Read data, registered
    output wire                pslverr_o,      // Error: unaligned, unmapped or read-only write
    // Protection logic side, same clock
    input  wire [CODE_W-1:0]   fault_code_i,   // Active fault code, 0 none
    input  wire [15:0]         freq_cmd_i,     // Frequency command, 0.01 Hz
    input  wire [15:0]         out_freq_i,     // Output frequency, 0.01 Hz
    input  wire [15:0]         out_volt_i,     // Output voltage, 0.1 V
    input  wire [15:0]         bus_volt_i,     // DC bus voltage, 0.1 V
    input  wire [15:0]         out_curr_i,     // Output current, 0.01 A
    input  wire [15:0]         sw_temp_i,      // Switch temp, signed 0.1 C
    input  wire [15:0]         motor_speed_i,  // Speed, signed rpm
    input  wire [15:0]         torque_cmd_i,   // Torque cmd, signed %
    input  wire [15:0]         in_terms_i,     // Input terminal states
    input  wire [15:0]         out_terms_i,    // Output terminal states
    input  wire [15:0]         drive_stat_i,   // Drive status word
    // Terminal side
    output wire [NUM_TERM-1:0] fault_term_o    // Fault-driven terminals, high active
);

    ////////////////////////////////////////////////////////////////////////
    // Classification

    // Fault code to category bits
    function [`FCO_CAT_W-1:0] fco_classify;
        input [CODE_W-1:0] code;
        begin
            fco_classify = {`FCO_CAT_W{1'b0}};
            case (code)
                8'd3, 8'd6, 8'd28, 8'd79, 8'd80,
                8'd81, 8'd82, 8'd83, 8'd84: begin
                    fco_classify[`FCO_CAT_CURRENT] = 1'b1;
                end
                8'd7, 8'd8, 8'd9, 8'd10, 8'd11,
                8'd12, 8'd13, 8'd14, 8'd15, 8'd62: begin
                    fco_classify[`FCO_CAT_VOLTAGE] = 1'b1;
                end
                8'd16, 8'd18, 8'd21, 8'd22,
                8'd26, 8'd87: begin
                    fco_classify[`FCO_CAT_OVERLOAD] = 1'b1;
                end
                8'd31, 8'd33, 8'd34, 8'd35,
                8'd36, 8'd37, 8'd52: begin
                    fco_classify[`FCO_CAT_SYSTEM] = 1'b1;
                end
                8'd49, 8'd50, 8'd51: begin
                    fco_classify[`FCO_CAT_EXTERNAL] = 1'b1;
                end
                8'd54, 8'd55, 8'd56, 8'd57, 8'd58,
                8'd101, 8'd102, 8'd104, 8'd105,
                8'd106, 8'd107, 8'd111, 8'd121,
                8'd123, 8'd124, 8'd126, 8'd127: begin
                    fco_classify[`FCO_CAT_COMM] = 1'b1;
                end
                default: begin
                    fco_classify = {`FCO_CAT_W{1'b0}};
                end
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Fault event detection

    reg  [CODE_W-1:0]     code_prev_reg;
    reg  [`FCO_CAT_W-1:0] cat_reg;
    reg  [CODE_W-1:0]     code_reg;
    reg  [15:0]           fault_cnt_reg;
    wire                  fault_evt;

    // New fault: nonzero code that differs from the last cycle's code.
    // A code held steady is one fault, not one per cycle.
    assign fault_evt = (fault_code_i != `FCO_NO_FAULT) &&
                       (fault_code_i != code_prev_reg);

    // Categories follow the active fault and clear with it
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            code_prev_reg <= `FCO_NO_FAULT;
            code_reg      <= `FCO_NO_FAULT;
            cat_reg       <= {`FCO_CAT_W{1'b0}};
            fault_cnt_reg <= 16'h0000;
        end else begin
            code_prev_reg <= fault_code_i;
            code_reg      <= fault_code_i;
            cat_reg       <= fco_classify(fault_code_i);
            if (fault_evt) begin
                fault_cnt_reg <= fault_cnt_reg + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Snapshot bank

    reg  [15:0] snap_mem [0:`FCO_SNAP_NUM-1];
    wire [15:0] live     [0:`FCO_SNAP_NUM-1];

    assign live[`FCO_SNAP_FCMD]    = freq_cmd_i;
    assign live[`FCO_SNAP_OFREQ]   = out_freq_i;
    assign live[`FCO_SNAP_OVOLT]   = out_volt_i;
    assign live[`FCO_SNAP_BUSV]    = bus_volt_i;
    assign live[`FCO_SNAP_CURR]    = out_curr_i;
    assign live[`FCO_SNAP_TEMP]    = sw_temp_i;
    assign live[`FCO_SNAP_SPEED]   = motor_speed_i;
    assign live[`FCO_SNAP_TORQ]    = torque_cmd_i;
    assign live[`FCO_SNAP_INTERM]  = in_terms_i;
    assign live[`FCO_SNAP_OUTTERM] = out_terms_i;
    assign live[`FCO_SNAP_DSTAT]   = drive_stat_i;

    // One capture flop per slot, all on the same event
    genvar gs;
    generate
        for (gs = 0; gs < `FCO_SNAP_NUM; gs = gs + 1) begin : g_snap
            // signed and raw words kept as is
            always @(posedge clk_sys_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    snap_mem[gs] <= `FCO_RST_SNAP;
                end else if (fault_evt) begin
                    snap_mem[gs] <= live[gs];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Address regions

    localparam [2:0] RGN_MASK   = 3'h0;
    localparam [2:0] RGN_FSEL   = 3'h1;
    localparam [2:0] RGN_SNAP   = 3'h2;
    localparam [2:0] RGN_STATUS = 3'h3;
    localparam [2:0] RGN_NONE   = 3'h4;

    // Region of a byte address. Every write strobe uses it, so the
    // strobes can never disagree on where a register sits.
    function [2:0] fco_region;
        input [7:0] addr;
        begin
            if (addr[1:0] != 2'b00) begin
                fco_region = RGN_NONE;
            end else if (addr < `FCO_ADDR_FSEL0) begin
                fco_region = RGN_MASK;
            end else if (addr < `FCO_ADDR_SNAP0) begin
                fco_region = RGN_FSEL;
            end else if (addr < `FCO_ADDR_STATUS) begin
                fco_region = RGN_SNAP;
            end else if (addr == `FCO_ADDR_STATUS) begin
                fco_region = RGN_STATUS;
            end else begin
                fco_region = RGN_NONE;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Software registers

    reg  [15:0]   mask_reg [0:3];
    reg  [7:0]    fsel_reg [0:NUM_TERM-1];
    reg           pready_reg;
    reg  [31:0]   prdata_reg;
    reg           pslverr_reg;
    reg  [31:0]   rd_next;
    reg           err_next;
    wire          setup_ph;
    wire          wr_acc;
    wire [7:0]    snap_off;
    wire [3:0]    snap_idx;
    wire          wr_ok;
    wire [3:0]    mask_we;
    wire [NUM_TERM-1:0] fsel_we;
    integer       i;

    assign setup_ph = psel_i && !penable_i;
    assign wr_acc   = psel_i && penable_i && pready_reg && pwrite_i;
    assign wr_ok    = wr_acc && !pslverr_reg;

    // Snapshot slot from the address; only bits 5:2 can name a slot
    assign snap_off = paddr_i - `FCO_ADDR_SNAP0;
    assign snap_idx = snap_off[5:2];

    // One write strobe per register; a refused access strobes nothing
    genvar gw;
    generate
        for (gw = 0; gw < 4; gw = gw + 1) begin : g_mask_we
            assign mask_we[gw] = wr_ok && (fco_region(paddr_i) == RGN_MASK) &&
                                 (paddr_i[3:2] == gw);
        end
        for (gw = 0; gw < NUM_TERM; gw = gw + 1) begin : g_fsel_we
            assign fsel_we[gw] = wr_ok && (fco_region(paddr_i) == RGN_FSEL) &&
                                 (paddr_i[3:2] == gw);
        end
    endgenerate

    // Address decode; snapshot and status words are read only
    always @* begin
        rd_next  = 32'h0000_0000;
        err_next = 1'b0;
        if (paddr_i[1:0] != 2'b00) begin
            err_next = 1'b1;
        end else if (paddr_i < `FCO_ADDR_FSEL0) begin
            rd_next = {16'h0000, mask_reg[paddr_i[3:2]]};
        end else if (paddr_i < `FCO_ADDR_SNAP0) begin
            if (paddr_i[3:2] < NUM_TERM) begin
                rd_next = {24'h0000_00, fsel_reg[paddr_i[3:2]]};
            end else begin
                err_next = 1'b1;
            end
        end else if (paddr_i < `FCO_ADDR_STATUS) begin
            if (snap_idx < `FCO_SNAP_NUM) begin
                rd_next = {16'h0000, snap_mem[snap_idx]};
            end else begin
                err_next = 1'b1;
            end
        end else if (paddr_i == `FCO_ADDR_STATUS) begin
            rd_next[`FCO_STAT_CODE_LSB +: 8]       = code_reg;
            rd_next[`FCO_STAT_CAT_LSB +: `FCO_CAT_W] = cat_reg;
            rd_next[`FCO_STAT_CNT_LSB +: 16]       = fault_cnt_reg;
        end else begin
            err_next = 1'b1;
        end
        if (err_next) begin
            rd_next = 32'h0000_0000;
        end
    end

    // Answer one cycle after setup: pready high in the first access cycle
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup_ph;
            if (setup_ph) begin
                prdata_reg  <= pwrite_i ? 32'h0000_0000 : rd_next;
                pslverr_reg <= err_next || (pwrite_i &&
                               (paddr_i >= `FCO_ADDR_SNAP0));
            end else begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    // Mask and function select writes; low bits of the word only
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (i = 0; i < 4; i = i + 1) begin
                mask_reg[i] <= `FCO_RST_MASK;
            end
            for (i = 0; i < NUM_TERM; i = i + 1) begin
                fsel_reg[i] <= `FCO_RST_FSEL;
            end
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (mask_we[i]) begin
                    mask_reg[i] <= pwdata_i[15:0];
                end
            end
            // Strobes already exclude refused accesses
            for (i = 0; i < NUM_TERM; i = i + 1) begin
                if (fsel_we[i]) begin
                    fsel_reg[i] <= pwdata_i[7:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault output terminals

    reg [NUM_TERM-1:0] term_reg;
    genvar gt;
    generate
        for (gt = 0; gt < NUM_TERM; gt = gt + 1) begin : g_term
            wire [7:0] sel_off = fsel_reg[gt] - `FCO_FUNC_MASK1;
            wire       is_flt = (fsel_reg[gt] >= `FCO_FUNC_MASK1) &&
                                (fsel_reg[gt] <= `FCO_FUNC_MASK4);
            // active while the fault category hits the mask.
            // Other function codes belong to other logic, so stay low here.
            always @(posedge clk_sys_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    term_reg[gt] <= 1'b0;
                end else begin
                    term_reg[gt] <= is_flt &&
                        (|(mask_reg[sel_off[1:0]][`FCO_CAT_W-1:0] & cat_reg));
                end
            end
        end
    endgenerate

    assign fault_term_o = term_reg;
    assign pready_o     = pready_reg;
    assign prdata_o     = prdata_reg;
    assign pslverr_o    = pslverr_reg;

endmodule
`default_nettype wire

// ==== fco_top_tb.sv ====
// Self-checking bench of the fault category block
`timescale 1ns/1ps
`default_nettype none
`include "fco_consts.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module fco_top_tb;
    logic         clk_sys_i = 1'b0;
    logic         nrst_i    = 1'b0;
    logic         psel_i    = 1'b0;
    logic         penable_i = 1'b0;
    logic         pwrite_i  = 1'b0;
    logic [7:0]   paddr_i   = 8'h00;
    logic [31:0]  pwdata_i  = 32'h0000_0000;
    wire  [31:0]  prdata_o;
    wire          pready_o;
    wire          pslverr_o;
    wire  [7:0]   code;
    wire  [175:0] live;
    wire  [3:0]   fault_term_o;
    int           errors    = 0;
    int           cmp_count = 0;
    logic [31:0]  rd;
    logic         er;
    logic [15:0]  mask [0:3] = '{16'h0001, 16'h0002, 16'h006C, 16'hFF90};

    always #4 clk_sys_i = ~clk_sys_i;

    fco_prot_model prot (.clk_sys_i(clk_sys_i), .code_o(code), .live_o(live));
    fco_top dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
        .prdata_o(prdata_o), .pslverr_o(pslverr_o), .fault_code_i(code), .freq_cmd_i(live[15:0]),
        .out_freq_i(live[31:16]), .out_volt_i(live[47:32]), .bus_volt_i(live[63:48]),
        .out_curr_i(live[79:64]), .sw_temp_i(live[95:80]), .motor_speed_i(live[111:96]),
        .torque_cmd_i(live[127:112]), .in_terms_i(live[143:128]), .out_terms_i(live[159:144]),
        .drive_stat_i(live[175:160]), .fault_term_o(fault_term_o));

    task conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // One APB transfer, held until ready is sampled
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        if (pready_o !== 1'b1) begin
            errors++;
            conclude();
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, e)
        `CHK(er, ee)
    endtask

    function automatic logic [6:0] cat_of(input logic [7:0] c);
        case (c) inside
            3, 6, 28, [79:84]: return 7'h01;
            [7:15], 62: return 7'h02;
            16, 18, 21, 22, 26, 87: return 7'h04;
            31, [33:37], 52: return 7'h08;
            [49:51]: return 7'h20;
            [54:58], 101, 102, [104:107], 111, 121, 123, 124, 126, 127: return 7'h40;
            default: return 7'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////
    // Reset values, refused accesses
    task t_reset_map;
        // 0x4C lies past the last snapshot slot and is unmapped
        for (int a = 0; a <= 8'h50; a += 4) rdchk(8'(a), 32'h0000_0000, a == 8'h4C);
        rdchk(8'h54, 32'h0000_0000, 1'b1);
        rdchk(8'h02, 32'h0000_0000, 1'b1);
        apb(1'b1, `FCO_ADDR_SNAP0, 32'h0000_1234);
        `CHK(er, 1'b1)
        rdchk(`FCO_ADDR_SNAP0, 32'h0000_0000, 1'b0);
    endtask

    // Capture on new code only, later fault overwrites all slots
    task t_snapshot;
        prot.set_live(16'h1000);
        prot.set_fault(8'd49);
        prot.set_live(16'h2000);
        for (int k = 0; k < 11; k++) rdchk(`FCO_ADDR_SNAP0 + 8'(4*k), 32'h1000 + k, 1'b0);
        rdchk(`FCO_ADDR_STATUS, 32'h0001_2031, 1'b0);
        prot.set_fault(8'd127);
        prot.set_live(16'h3000);
        prot.set_fault(8'd0);
        for (int k = 0; k < 11; k++) rdchk(`FCO_ADDR_SNAP0 + 8'(4*k), 32'h2000 + k, 1'b0);
        rdchk(`FCO_ADDR_STATUS, 32'h0002_0000, 1'b0);
        // Negative and full-range words; code stays active afterwards
        prot.set_live(16'hEDC0);
        prot.set_fault(8'd87);
        prot.set_live(16'h0000);
        for (int k = 0; k < 11; k++) rdchk(`FCO_ADDR_SNAP0 + 8'(4*k), 32'hEDC0 + k, 1'b0);
        rdchk(`FCO_ADDR_STATUS, 32'h0003_0457, 1'b0);
    endtask

    // Mask width, then terminals 0..3 on functions 35..38
    task t_masks;
        apb(1'b1, `FCO_ADDR_MASK1, 32'hFFFF_FFFF);
        rdchk(`FCO_ADDR_MASK1, 32'h0000_FFFF, 1'b0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'(4*i), {16'h0000, mask[i]});
            apb(1'b1, `FCO_ADDR_FSEL0 + 8'(4*i), 32'h23 + i);
        end
    endtask

    // Codes 0 to 127: category in status and on the terminals
    task t_classify;
        logic [6:0] cat;
        logic [3:0] et;
        for (int c = 0; c < 128; c++) begin
            cat = cat_of(8'(c));
            for (int i = 0; i < 4; i++) et[i] = |(cat & mask[i][6:0]);
            prot.set_fault(8'(c));
            repeat (2) @(posedge clk_sys_i);
            #1;
            `CHK(fault_term_o, et)
            rdchk(`FCO_ADDR_STATUS, {16'(3 + c), 1'b0, cat, 8'(c)}, 1'b0);
        end
        apb(1'b1, `FCO_ADDR_FSEL0, 32'h22);
        prot.set_fault(8'd3);
        repeat (2) @(posedge clk_sys_i);
        #1;
        `CHK(fault_term_o, 4'h0)
    endtask

    initial begin
        repeat (16) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        t_reset_map();
        t_snapshot();
        t_masks();
        t_classify();
        conclude();
    end
endmodule
`default_nettype wire
